// ==== csp_pkg.sv ====
// Purpose: Constants for the clock source and prescaler control block.
// Assumes: Register offsets are byte addresses on the plain register port.
// Notes:   Oscillator and PLL clocks appear as one-cycle tick pulses.
package csp_pkg;
   // =====================================================
   // Register offsets.
   localparam logic [7:0] A_MAIN_CTRL = 8'h00;
   localparam logic [7:0] A_CLK_SEL   = 8'h04;
   localparam logic [7:0] A_PLL0      = 8'h20;
   localparam logic [7:0] A_PLL1      = 8'h24;
   localparam logic [7:0] A_OSCC0     = 8'h28;
   localparam logic [7:0] A_OSCC1     = 8'h2c;
   localparam logic [7:0] A_OSCC32    = 8'h30;
   localparam logic [7:0] A_INT_EN    = 8'h40;
   localparam logic [7:0] A_INT_STAT  = 8'h4c;
   localparam logic [7:0] A_OSC_STAT  = 8'h54;
   // =====================================================
   // Field positions.
   localparam int MC_OSC0EN  = 2;
   localparam int MC_OSC1EN  = 3;
   localparam int CK_CPU_LSB = 0;
   localparam int CK_HSPD_LSB = 8;
   localparam int CK_PERA_LSB = 16;
   localparam int CK_PERB_LSB = 24;
   localparam int CK_DIV_BIT = 7;
   localparam int PL_EN      = 0;
   localparam int PL_OSC     = 1;
   localparam int PL_OPT_LSB = 2;
   localparam int PL_DIV_LSB = 8;
   localparam int PL_MUL_LSB = 16;
   localparam int OC_MODE    = 0;
   localparam int OC_SUT_LSB = 8;
   localparam int O32_EN     = 0;
   localparam int O32_MODE   = 8;
   localparam int O32_SUT    = 16;
   localparam int ST_OSC0    = 0;
   localparam int ST_OSC1    = 1;
   localparam int ST_LOCK0   = 2;
   localparam int ST_LOCK1   = 3;
   localparam int ST_CLK_RDY = 5;
   localparam int ST_OSC32   = 7;
   // =====================================================
   // Reset values, counts and encodings.
   localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
   localparam logic [7:0]  ST_RST     = 8'h00;
   localparam logic [1:0]  RC_START   = 2'h3;
   localparam int          SUT_LOG0   = 2;
   localparam int          SUT_CW     = 17;
   localparam logic [3:0]  LOCK_FILT  = 4'h8;
   localparam logic [1:0]  MC_SLOW    = 2'h0;
   localparam logic [1:0]  MC_OSC0    = 2'h1;
   localparam logic [1:0]  MC_PLL0    = 2'h2;
   typedef enum logic [1:0] {CK_IDLE = 2'b00, CK_PEND = 2'b01} csp_ck_t;
endpackage : csp_pkg

// ==== csp_ctrl.sv ====
// Purpose: Clock sources, start-up masking, PLL lock masking, main clock
//          selection and 8-bit prescaler with a clock-ready handshake.
// Assumes: Every clock is a one-cycle tick on i_sys_clk (40 MHz).
// Notes:   i_por clears the 32 kHz oscillator state; i_rst clears the rest.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps

// =====================================================
// Start-up masking counter for one oscillator.
module csp_osc_start #(
   parameter int CW = 17
) (
   input  wire logic          i_sys_clk,
   input  wire logic          i_rst,
   input  wire logic          i_run,
   input  wire logic          i_tick,
   input  wire logic [2:0]    i_sut,
   output logic               o_rdy
);
   import csp_pkg::*;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] lim;
   // Start-up length doubles twice per step of the start-up field.
   assign lim   = CW'(1) << (SUT_LOG0 + 2 * int'(i_sut));
   assign o_rdy = i_run && (cnt_q >= lim);
   // Counting restarts whenever the oscillator stops.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= '0;
      end else if (!i_run) begin
         cnt_q <= '0;
      end else if (i_tick && !o_rdy) begin
         cnt_q <= cnt_q + CW'(1);
      end
   end
endmodule : csp_osc_start

// =====================================================
// Top level.
module csp_ctrl #(
   parameter int PW = 8
) (
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   input  wire logic              i_por,
   input  wire logic [7:0]        i_addr,
   input  wire logic [31:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic [31:0]            o_rdata,
   input  wire logic              i_rc_tick,
   input  wire logic [1:0]        i_osc_tick,
   input  wire logic              i_osc32_tick,
   input  wire logic [1:0]        i_pll_tick,
   input  wire logic [1:0]        i_pll_lock_raw,
   input  wire logic              i_sleep_osc_off,
   input  wire logic              i_sleep_static,
   output logic                   o_rc_run,
   output logic                   o_slow_ce,
   output logic [1:0]             o_osc_en,
   output logic [1:0]             o_osc_mode,
   output logic [1:0]             o_osc_gate,
   output logic                   o_osc32_en,
   output logic                   o_osc32_mode,
   output logic                   o_osc32_gate,
   output logic [1:0]             o_pll_en,
   output logic [1:0]             o_pll_ref,
   output logic [1:0][5:0]        o_pll_num,
   output logic [1:0][3:0]        o_pll_den,
   output logic [1:0]             o_pll_half,
   output logic [1:0]             o_pll_gate,
   output logic                   o_main_ce,
   output logic                   o_cpu_ce,
   output logic                   o_hspd_ce,
   output logic                   o_pera_ce,
   output logic                   o_perb_ce,
   output logic                   o_clk_rdy,
   output logic                   o_event
);
   import csp_pkg::*;

   // =====================================================
   // Registers.
   logic [31:0]     main_ctrl_q, clk_sel_new_q, clk_sel_act_q, oscc0_q, oscc1_q;
   logic [31:0]     osc32_q, int_en_q, rdata_q;
   logic [1:0][31:0] pll_q;
   logic [1:0]      act_src_q;
   logic [PW-1:0]   psc_q;
   csp_ck_t         ck_st_q;
   logic [1:0]      rc_cnt_q;
   logic [3:0]      lock_cnt_q [2];
   logic [7:0]      st_q;
   logic            main_q, cpu_q, pera_q, perb_q, ev_q;

   // =====================================================
   // Address decode and derived fields.
   wire wr_mc   = i_wr && (i_addr == A_MAIN_CTRL);
   wire wr_ck   = i_wr && (i_addr == A_CLK_SEL);
   wire wr_p0   = i_wr && (i_addr == A_PLL0);
   wire wr_p1   = i_wr && (i_addr == A_PLL1);
   wire wr_oc0  = i_wr && (i_addr == A_OSCC0);
   wire wr_oc1  = i_wr && (i_addr == A_OSCC1);
   wire wr_o32  = i_wr && (i_addr == A_OSCC32);
   wire wr_ier  = i_wr && (i_addr == A_INT_EN);
   wire [1:0] wr_pll = {wr_p1, wr_p0};
   wire [1:0] main_src_sel = main_ctrl_q[1:0];

   // Slow clock runs except in static sleep, ready after three RC cycles.
   wire rc_rdy  = (rc_cnt_q == RC_START);
   wire slow_tk = i_rc_tick && rc_rdy && !i_sleep_static;

   // Main oscillators: enable bits, mode bits, sleep shutdown.
   wire [1:0] osc_run  = {main_ctrl_q[MC_OSC1EN], main_ctrl_q[MC_OSC0EN]}
                         & {2{!i_sleep_osc_off}};
   wire [1:0] osc_rdy;
   wire       osc32_run = osc32_q[O32_EN] && !i_sleep_static;
   wire       osc32_rdy;
   wire [1:0] pll_lock;

   // =====================================================
   // Oscillator start-up masking, timed by the slow clock.
   csp_osc_start #(.CW(SUT_CW)) u_osc0 (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_run     (osc_run[0]),
      .i_tick    (slow_tk),
      .i_sut     (oscc0_q[OC_SUT_LSB +: 3]),
      .o_rdy     (osc_rdy[0])
   );
   csp_osc_start #(.CW(SUT_CW)) u_osc1 (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_run     (osc_run[1]),
      .i_tick    (slow_tk),
      .i_sut     (oscc1_q[OC_SUT_LSB +: 3]),
      .o_rdy     (osc_rdy[1])
   );
   // The 32 kHz counter is kept across all resets but power-on.
   csp_osc_start #(.CW(SUT_CW)) u_osc32 (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_por),
      .i_run     (osc32_run),
      .i_tick    (slow_tk),
      .i_sut     (osc32_q[O32_SUT +: 3]),
      .o_rdy     (osc32_rdy)
   );

   // =====================================================
   // PLL configuration outputs, lock flags and clock masking.
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pll
         wire [3:0] mul = pll_q[g][PL_MUL_LSB +: 4];
         wire [3:0] dv  = pll_q[g][PL_DIV_LSB +: 4];
         wire [5:0] m1  = 6'(mul) + 6'h01;
         wire       ref_sel = pll_q[g][PL_OSC];
         // A write that enables or changes reference or multiplier unlocks.
         wire relock = wr_pll[g] && ((i_wdata[PL_EN] && !pll_q[g][PL_EN])
                       || (i_wdata[PL_OSC] != ref_sel)
                       || (i_wdata[PL_MUL_LSB +: 4] != mul));
         wire lock_ok = pll_q[g][PL_EN] && !i_sleep_osc_off
                        && i_pll_lock_raw[g] && osc_rdy[ref_sel];
         assign o_pll_num[g]  = (dv == 4'h0) ? 6'(m1 << 1) : m1;
         assign o_pll_den[g]  = (dv == 4'h0) ? 4'h1 : dv;
         assign o_pll_half[g] = pll_q[g][PL_OPT_LSB + 1];
         assign o_pll_en[g]   = pll_q[g][PL_EN];
         assign o_pll_ref[g]  = ref_sel;
         assign pll_lock[g]   = (lock_cnt_q[g] == LOCK_FILT);
         assign o_pll_gate[g] = pll_lock[g];
         // Lock must be seen for a filter period before it counts.
         always_ff @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
               lock_cnt_q[g] <= '0;
            end else if (relock || !lock_ok) begin
               lock_cnt_q[g] <= '0;
            end else if (!pll_lock[g]) begin
               lock_cnt_q[g] <= lock_cnt_q[g] + 4'h1;
            end
         end
      end
   endgenerate

   // =====================================================
   // Main clock source selection.
   function automatic logic src_tick(input logic [1:0] s, input logic sl,
                                     input logic o0, input logic p0);
      case (s)
         MC_OSC0: src_tick = o0;
         MC_PLL0: src_tick = p0;
         default: src_tick = sl;
      endcase
   endfunction : src_tick

   wire osc0_tk   = i_osc_tick[0] && osc_rdy[0];
   wire pll0_tk   = i_pll_tick[0] && pll_lock[0];
   wire main_tk   = src_tick(act_src_q, slow_tk, osc0_tk, pll0_tk);
   wire psc_wrap  = main_tk && (&psc_q);

   // Prescaler tap: undivided, or one pulse per 2^(sel+1) main ticks.
   function automatic logic tap(input logic [7:0] f, input logic [PW-1:0] p,
                                input logic t);
      logic [8:0] m;
      m = 9'((9'h002 << f[2:0]) - 9'h001);
      if (f[CK_DIV_BIT]) begin
         tap = t && ((p & m[PW-1:0]) == m[PW-1:0]);
      end else begin
         tap = t;
      end
   endfunction : tap

   // Source changes only on a tick of the old source, so no runt pulse.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         act_src_q <= MC_SLOW;
      end else if (main_tk) begin
         act_src_q <= main_src_sel;
      end
   end

   // =====================================================
   // Prescaler and clock select handshake.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         psc_q <= '0;
      end else if (main_tk) begin
         psc_q <= psc_q + PW'(1);
      end
   end

   // New settings wait for the common prescaler wrap, then apply together.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ck_st_q     <= CK_IDLE;
         clk_sel_new_q <= RST_ZERO;
         clk_sel_act_q <= RST_ZERO;
      end else begin
         case (ck_st_q)
            CK_IDLE: begin
               if (wr_ck) begin
                  clk_sel_new_q <= {i_wdata[31:16], i_wdata[7:0], i_wdata[7:0]};
                  ck_st_q     <= CK_PEND;
               end
            end
            CK_PEND: begin
               if (psc_wrap) begin
                  clk_sel_act_q <= clk_sel_new_q;
                  ck_st_q     <= CK_IDLE;
               end
            end
            default: ck_st_q <= CK_IDLE;
         endcase
      end
   end

   // Domain enables are registered taps of the shared prescaler.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         main_q <= 1'b0;
         cpu_q  <= 1'b0;
         pera_q <= 1'b0;
         perb_q <= 1'b0;
      end else begin
         main_q <= main_tk;
         cpu_q  <= tap(clk_sel_act_q[CK_CPU_LSB +: 8], psc_q, main_tk);
         pera_q <= tap(clk_sel_act_q[CK_PERA_LSB +: 8], psc_q, main_tk);
         perb_q <= tap(clk_sel_act_q[CK_PERB_LSB +: 8], psc_q, main_tk);
      end
   end

   // =====================================================
   // RC start-up, re-armed when static sleep stops the RC oscillator.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rc_cnt_q <= '0;
      end else if (i_sleep_static) begin
         rc_cnt_q <= '0;
      end else if (i_rc_tick && !rc_rdy) begin
         rc_cnt_q <= rc_cnt_q + 2'h1;
      end
   end

   // =====================================================
   // Software registers on the hard reset.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         main_ctrl_q <= RST_ZERO;
         oscc0_q  <= RST_ZERO;
         oscc1_q  <= RST_ZERO;
         pll_q    <= '0;
         int_en_q <= RST_ZERO;
      end else begin
         if (wr_mc)  main_ctrl_q <= i_wdata;
         if (wr_oc0) oscc0_q  <= i_wdata;
         if (wr_oc1) oscc1_q  <= i_wdata;
         if (wr_p0)  pll_q[0] <= i_wdata;
         if (wr_p1)  pll_q[1] <= i_wdata;
         if (wr_ier) int_en_q <= i_wdata;
      end
   end

   // The 32 kHz control register is cleared only by power-on reset.
   always_ff @(posedge i_sys_clk or posedge i_por) begin
      if (i_por) begin
         osc32_q <= RST_ZERO;
      end else if (wr_o32) begin
         osc32_q <= i_wdata;
      end
   end

   // =====================================================
   // Status, rising-edge events and read data.
   wire [7:0] status;
   assign status = 8'(osc_rdy[0]) << ST_OSC0 | 8'(osc_rdy[1]) << ST_OSC1
                 | 8'(pll_lock[0]) << ST_LOCK0 | 8'(pll_lock[1]) << ST_LOCK1
                 | 8'(o_clk_rdy) << ST_CLK_RDY | 8'(osc32_rdy) << ST_OSC32;
   wire [7:0] rises = status & ~st_q;

   wire [31:0] ck_rd = {clk_sel_new_q[31:16], clk_sel_new_q[7:0], clk_sel_new_q[7:0]};
   wire [31:0] rd_mux =
        (i_addr == A_MAIN_CTRL) ? main_ctrl_q :
        (i_addr == A_CLK_SEL)   ? ck_rd :
        (i_addr == A_PLL0)   ? pll_q[0] :
        (i_addr == A_PLL1)   ? pll_q[1] :
        (i_addr == A_OSCC0)  ? oscc0_q :
        (i_addr == A_OSCC1)  ? oscc1_q :
        (i_addr == A_OSCC32) ? osc32_q :
        (i_addr == A_INT_EN) ? int_en_q :
        (i_addr == A_INT_STAT || i_addr == A_OSC_STAT) ? 32'(status) : RST_ZERO;

   // Read data stand for one cycle only; enabled rises pulse the event.
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_q <= RST_ZERO;
         st_q    <= ST_RST;
         ev_q    <= 1'b0;
      end else begin
         rdata_q <= i_rd ? rd_mux : RST_ZERO;
         st_q    <= status;
         ev_q    <= |(rises & int_en_q[7:0]);
      end
   end

   // =====================================================
   // Output assignments.
   assign o_rdata      = rdata_q;
   assign o_rc_run     = !i_sleep_static;
   assign o_slow_ce    = slow_tk;
   assign o_osc_en     = osc_run;
   assign o_osc_mode   = {oscc1_q[OC_MODE], oscc0_q[OC_MODE]};
   assign o_osc_gate   = osc_rdy;
   assign o_osc32_en   = osc32_run;
   assign o_osc32_mode = osc32_q[O32_MODE];
   assign o_osc32_gate = osc32_rdy;
   assign o_main_ce    = main_q;
   assign o_cpu_ce     = cpu_q;
   assign o_hspd_ce    = cpu_q;
   assign o_pera_ce    = pera_q;
   assign o_perb_ce    = perb_q;
   assign o_clk_rdy    = (ck_st_q == CK_IDLE);
   assign o_event      = ev_q;

   // =====================================================
   // Assertions.
   property p_clk_rdy_drop;
      @(posedge i_sys_clk) disable iff (i_rst) wr_ck |=> !o_clk_rdy;
   endproperty
   a_clk_rdy_drop: assert property (p_clk_rdy_drop) else $error("clock ready not cleared");

   property p_clk_rdy_back;
      @(posedge i_sys_clk) disable iff (i_rst)
         (!o_clk_rdy && psc_wrap) |=> (o_clk_rdy && clk_sel_act_q == $past(clk_sel_new_q));
   endproperty
   a_clk_rdy_back: assert property (p_clk_rdy_back) else $error("setting not applied");

   property p_hspd_same;
      @(posedge i_sys_clk) disable iff (i_rst) o_hspd_ce == o_cpu_ce;
   endproperty
   a_hspd_same: assert property (p_hspd_same) else $error("high-speed bus differs from cpu");

   property p_rc_ready;
      @(posedge i_sys_clk) disable iff (i_rst)
         $rose(rc_rdy) |-> $past(i_rc_tick) && $past(rc_cnt_q) == 2'h2;
   endproperty
   a_rc_ready: assert property (p_rc_ready) else $error("rc start count wrong");

   property p_pll_relock;
      @(posedge i_sys_clk) disable iff (i_rst)
         (wr_p0 && i_wdata[PL_EN] && !pll_q[0][PL_EN]) |=> !o_pll_gate[0] [*8];
   endproperty
   a_pll_relock: assert property (p_pll_relock) else $error("pll gate open early");

   property p_osc_mask;
      @(posedge i_sys_clk) disable iff (i_rst) !o_osc_en[0] |-> !o_osc_gate[0];
   endproperty
   a_osc_mask: assert property (p_osc_mask) else $error("osc0 not masked");

   property p_cpu_div;
      @(posedge i_sys_clk) disable iff (i_rst)
         (o_cpu_ce && clk_sel_act_q[CK_CPU_LSB + CK_DIV_BIT]) |-> $past(psc_q[0]);
   endproperty
   a_cpu_div: assert property (p_cpu_div) else $error("cpu tap misaligned");

   property p_pera_undiv;
      @(posedge i_sys_clk) disable iff (i_rst)
         (main_tk && !clk_sel_act_q[CK_PERA_LSB + CK_DIV_BIT]) |=> o_pera_ce;
   endproperty
   a_pera_undiv: assert property (p_pera_undiv) else $error("bus a pulse missing");

   property p_src_switch;
      @(posedge i_sys_clk) disable iff (i_rst)
         (act_src_q != main_src_sel && !main_tk) |=> act_src_q == $past(act_src_q);
   endproperty
   a_src_switch: assert property (p_src_switch) else $error("source switched mid-cycle");

   property p_vco_ratio;
      @(posedge i_sys_clk) disable iff (i_rst)
         (pll_q[1][PL_DIV_LSB +: 4] == 4'h0) |-> (o_pll_den[1] == 4'h1
            && o_pll_num[1] == 6'(2 * (pll_q[1][PL_MUL_LSB +: 4] + 1)));
   endproperty
   a_vco_ratio: assert property (p_vco_ratio) else $error("vco ratio wrong");
endmodule : csp_ctrl

// ==== csp_tb.sv ====
// Purpose: Self-checking bench for the clock source and prescaler control block.
// Assumes: Source clocks are tick pulses made here; start-up select 0 keeps waits short.
// Notes:   Only mismatches and the verdict are printed.
`timescale 1ns/1ps

// =====================================================
// Bench top.
module tb;
   import csp_pkg::*;
   logic i_sys_clk = 1'b0, i_rst = 1'b1, i_por = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic i_rc_tick = 1'b0, i_osc32_tick = 1'b0, i_sleep_osc_off = 1'b0, i_sleep_static = 1'b0;
   logic [1:0] i_osc_tick = 2'h0, i_pll_tick = 2'h0, i_pll_lock_raw = 2'h0;
   logic [31:0] o_rdata;
   logic o_rc_run, o_slow_ce, o_osc32_en, o_osc32_mode, o_osc32_gate, o_main_ce, o_cpu_ce;
   logic o_hspd_ce, o_pera_ce, o_perb_ce, o_clk_rdy, o_event;
   logic [1:0] o_osc_en, o_osc_mode, o_osc_gate, o_pll_en, o_pll_ref, o_pll_half, o_pll_gate;
   logic [1:0][5:0] o_pll_num;
   logic [1:0][3:0] o_pll_den;
   int err_count = 0, check_count = 0, cyc = 0, k, n_m, n_c, n_h, n_a, n_b;
   logic cnt_on = 1'b0, ev_seen;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} csp_row_t;
   csp_row_t rows[7];

   csp_ctrl dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_por(i_por), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rc_tick(i_rc_tick),
      .i_osc_tick(i_osc_tick), .i_osc32_tick(i_osc32_tick), .i_pll_tick(i_pll_tick),
      .i_pll_lock_raw(i_pll_lock_raw), .i_sleep_osc_off(i_sleep_osc_off),
      .i_sleep_static(i_sleep_static), .o_rc_run(o_rc_run), .o_slow_ce(o_slow_ce),
      .o_osc_en(o_osc_en), .o_osc_mode(o_osc_mode), .o_osc_gate(o_osc_gate),
      .o_osc32_en(o_osc32_en), .o_osc32_mode(o_osc32_mode), .o_osc32_gate(o_osc32_gate),
      .o_pll_en(o_pll_en), .o_pll_ref(o_pll_ref), .o_pll_num(o_pll_num), .o_pll_den(o_pll_den),
      .o_pll_half(o_pll_half), .o_pll_gate(o_pll_gate), .o_main_ce(o_main_ce),
      .o_cpu_ce(o_cpu_ce), .o_hspd_ce(o_hspd_ce), .o_pera_ce(o_pera_ce),
      .o_perb_ce(o_perb_ce), .o_clk_rdy(o_clk_rdy), .o_event(o_event));

   // =====================================================
   // Clock, source ticks, pulse counters and the hang limit.
   always #12.5 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      i_rc_tick <= (cyc % 4 == 0);
      i_osc32_tick <= (cyc % 4 == 2);
      i_osc_tick <= {2{cyc[0]}};
      i_pll_tick <= {2{~cyc[0]}};
      if (cnt_on) begin
         n_m += o_main_ce; n_c += o_cpu_ce; n_h += o_hspd_ce; n_a += o_pera_ce; n_b += o_perb_ce;
      end
      if (cyc == 20000) begin
         err_count++;
         stop_test();
      end
   end

   // =====================================================
   // Shared helpers for checks and register traffic.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_sys_clk);
      i_rd <= 1'b1; i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 chk("rdata", e, o_rdata);
   endtask : rd
   // Counts ce pulses over 256 cycles, which is 128 ticks of a source toggling every cycle.
   task automatic win();
      #1;
      n_m = 0; n_c = 0; n_h = 0; n_a = 0; n_b = 0;
      cnt_on = 1'b1;
      repeat (256) @(posedge i_sys_clk);
      #1 cnt_on = 1'b0;
   endtask : win
   task automatic stop_test();
      if (err_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test

   // =====================================================
   // Main sequence.
   initial begin
      rows = '{'{A_MAIN_CTRL, 32'hc, 32'hc}, '{A_OSCC0, 32'h1, 32'h1}, '{A_OSCC1, 32'h0, 32'h0},
               '{A_INT_EN, 32'haf, 32'haf}, '{A_PLL0, 32'h0003_010b, 32'h0003_010b},
               '{A_PLL1, 32'h0002_0001, 32'h0002_0001}, '{8'h10, 32'hffff_ffff, 32'h0}};
      repeat (2) @(posedge i_sys_clk);
      #1 chk("clk_rdy_rst", 32'h1, o_clk_rdy);
      chk("en_rst", 32'h0, {o_osc_en, o_pll_en, o_osc_gate, o_pll_gate});
      @(posedge i_sys_clk);
      i_rst <= 1'b0; i_por <= 1'b0; i_pll_lock_raw <= 2'h3;
      rd(A_OSC_STAT, 32'h20);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      chk("osc_ctl", 32'h35, {o_osc_en, o_osc_mode, o_pll_half});
      chk("pll_ctl", 32'h7, {o_pll_en, o_pll_ref[0]});
      chk("pll_ratio", {6'd6, 4'd1, 6'd4, 4'd1}, {o_pll_num[1], o_pll_den[1],
          o_pll_num[0], o_pll_den[0]});
      for (k = 0; k < 400 && o_pll_gate !== 2'h3; k++) @(posedge i_sys_clk);
      #1 chk("gates", 32'hf, {o_osc_gate, o_pll_gate});
      rd(A_INT_STAT, 32'h2f);
      // Changing the multiplier must drop the lock and mask the clock.
      wr(A_PLL0, 32'h0004_010b);
      @(posedge i_sys_clk);
      #1 chk("unlock", 32'h0, o_pll_gate[0]);
      wr(A_MAIN_CTRL, 32'hd);
      repeat (8) @(posedge i_sys_clk);
      win();
      chk("main_osc0", 32'd128, n_m);
      chk("undiv", 32'd128, n_c);
      wr(A_CLK_SEL, 32'h8283_5581);
      #1 chk("clk_rdy_pend", 32'h0, o_clk_rdy);
      // No new select write until the pending setting has been applied.
      for (k = 0; k < 1200 && o_clk_rdy !== 1'b1; k++) @(posedge i_sys_clk);
      ev_seen = 1'b0;
      for (k = 0; k < 4; k++) begin
         #1 ev_seen |= (o_event === 1'b1);
         @(posedge i_sys_clk);
      end
      chk("ck_event", 32'h1, ev_seen);
      rd(A_CLK_SEL, 32'h8283_8181);
      win();
      chk("cpu_div", 32'd32, n_c);
      chk("hspd_cpu", 32'd32, n_h);
      chk("pba_pbb", {16'd8, 16'd16}, {n_a[15:0], n_b[15:0]});
      // The 32 kHz oscillator must outlive a hard reset but not a power-on reset.
      wr(A_OSCC32, 32'h101);
      @(posedge i_sys_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      #1 chk("o32_hard", 32'h3, {o_osc_en, o_osc32_en, o_osc32_mode});
      @(posedge i_sys_clk);
      i_rst <= 1'b1; i_por <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0; i_por <= 1'b0;
      #1 chk("o32_por", 32'h0, o_osc32_en);
      wr(A_MAIN_CTRL, 32'h4);
      @(posedge i_sys_clk);
      i_sleep_osc_off <= 1'b1; i_sleep_static <= 1'b1;
      @(posedge i_sys_clk);
      #1 chk("sleep", 32'h0, {o_osc_en, o_rc_run, o_slow_ce});
      stop_test();
   end
endmodule : tb
